/* File: core/gpt_pkg.sv */
// Package: register map, field positions, reset values and types of the gated prescaled timer
package gpt_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_COUNT = 4'h4;
	localparam logic [3:0] OFS_PERIOD = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;
	localparam logic [3:0] OFS_ENABLE = 4'h2;
	localparam int ADDR_W = 4;

	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int BIT_RUN = 15;
	localparam int BIT_IDLE_HALT = 13;
	localparam int BIT_GATE = 6;
	localparam int BIT_PS_HI = 5;
	localparam int BIT_PS_LO = 4;
	localparam int BIT_SYNC = 2;
	localparam int BIT_CLK_SEL = 1;
	localparam logic [15:0] CONTROL_MASK = 16'ha076;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;

	// ------------------------------------------------------------
	// Status / interrupt bits
	// ------------------------------------------------------------
	localparam int IRQ_W = 2;
	localparam int IRQ_MATCH = 0;
	localparam int IRQ_GATE_FALL = 1;

	// ------------------------------------------------------------
	// Prescale terminal counts (divide minus one)
	// ------------------------------------------------------------
	localparam logic [7:0] PS_DIV1 = 8'h00;
	localparam logic [7:0] PS_DIV8 = 8'h07;
	localparam logic [7:0] PS_DIV64 = 8'h3f;
	localparam logic [7:0] PS_DIV256 = 8'hff;

	typedef struct packed {
		logic run;
		logic idle_halt;
		logic gate_accumulate_enable;
		logic [1:0] prescale_select;
		logic ext_clock_synchronize;
		logic clock_source_select;
	} gpt_ctrl_s;

endpackage

/* File: core/gpt_sync.sv */
// Two-flop synchroniser for a pin level
module gpt_sync (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_r;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_r <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule

/* File: core/gpt_prescaler.sv */
// Prescaler: turns count-clock ticks into counter increments
module gpt_prescaler (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic clear_i,
	input wire logic tick_i,
	input wire logic [1:0] select_i,
	output logic inc_o
);
	logic [7:0] cnt_r;
	logic [7:0] terminal;
	logic at_end;

	assign terminal = (select_i == 2'h3) ? gpt_pkg::PS_DIV256 :
		(select_i == 2'h2) ? gpt_pkg::PS_DIV64 :
		(select_i == 2'h1) ? gpt_pkg::PS_DIV8 : gpt_pkg::PS_DIV1;
	assign at_end = (cnt_r >= terminal);
	assign inc_o = tick_i && at_end;

	always_ff @(posedge clk_i) begin
		if (srst_i || clear_i) begin
			cnt_r <= 8'h00;
		end else if (tick_i) begin
			cnt_r <= at_end ? 8'h00 : cnt_r + 8'h01;
		end
	end
endmodule

/* File: core/gpt_top.sv */
// Top: gated prescaled 16-bit timer with classic Wishbone slave
// What this block does
// - 16-bit counter, timer, sync or async counter
// - Interrupt when count equals period register
// - Gated mode also interrupts on gate fall
// - Keeps counting in idle or sleep states
// - Control bit 15 starts and stops counting
// - Control bit 13 halts counter in idle
// - Bit 6 gates accumulation, internal clock only
// - Bits 5-4 prescale by 1, 8, 64, 256
// - Bit 2 synchronises external clock when set
// - Bit 1 picks external pin or internal clock
// - Unimplemented control bits read as zero
// - Implemented control bits read/write, reset zero
// - Control write while running clears prescaler
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
module gpt_top (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [gpt_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_count_clock_pin_i,
	input wire logic gate_pin_i,
	input wire logic cpu_idle_i,
	output logic irq_o
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	gpt_pkg::gpt_ctrl_s ctrl_r;
	logic [15:0] count_r;
	logic [15:0] period_r;
	logic [gpt_pkg::IRQ_W-1:0] status_r;
	logic [gpt_pkg::IRQ_W-1:0] enable_r;
	logic ext_prev_r;
	logic gate_prev_r;

	logic ext_sync;
	logic gate_sync;
	logic ps_inc;
	logic [15:0] control_view;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic bus_req;
	logic bus_wr;
	logic hit_control;
	logic hit_count;
	logic hit_period;
	logic hit_status;
	logic hit_enable;
	logic hit_clear;
	logic [15:0] wr_lo;
	logic [31:0] rd_data;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_req && wb_we_i && (wb_sel_i[1:0] == 2'h3);
	assign hit_control = (wb_adr_i == gpt_pkg::OFS_CONTROL);
	assign hit_count = (wb_adr_i == gpt_pkg::OFS_COUNT);
	assign hit_period = (wb_adr_i == gpt_pkg::OFS_PERIOD);
	// Status reads here; a write to the same word is the clear register
	assign hit_status = (wb_adr_i == gpt_pkg::OFS_STATUS);
	assign hit_clear = hit_status;
	// Enable register has the status layout at an address of its own
	assign hit_enable = (wb_adr_i == gpt_pkg::OFS_ENABLE);
	assign wr_lo = wb_dat_i[15:0];

	assign control_view = {ctrl_r.run, 1'b0, ctrl_r.idle_halt, 6'h00, ctrl_r.gate_accumulate_enable,
		ctrl_r.prescale_select, 1'b0, ctrl_r.ext_clock_synchronize, ctrl_r.clock_source_select,
		1'b0};

	assign rd_data = hit_control ? {16'h0000, control_view} :
		hit_count ? {16'h0000, count_r} :
		hit_period ? {16'h0000, period_r} :
		hit_status ? {30'h0, status_r} :
		hit_enable ? {30'h0, enable_r} : 32'h0000_0000;

	// ------------------------------------------------------------
	// Count clock selection
	// ------------------------------------------------------------
	// Both modes see the pin through two flops; the synchronised mode adds a third stage
	logic ext_raw_r;
	logic ext_level;
	logic tick_ext;
	logic tick;
	logic gated_mode;
	logic running;
	logic gate_fall;
	logic match;

	gpt_sync u_ext_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.d_i(ext_count_clock_pin_i),
		.q_o(ext_sync)
	);

	gpt_sync u_gate_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.d_i(gate_pin_i),
		.q_o(gate_sync)
	);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ext_raw_r <= 1'b0;
		end else begin
			ext_raw_r <= ext_sync;
		end
	end

	assign ext_level = ctrl_r.ext_clock_synchronize ? ext_raw_r : ext_sync;
	assign tick_ext = ext_level && !ext_prev_r;
	assign gated_mode = ctrl_r.gate_accumulate_enable && !ctrl_r.clock_source_select;
	assign running = ctrl_r.run && !(ctrl_r.idle_halt && cpu_idle_i);
	assign tick = running && (ctrl_r.clock_source_select ? tick_ext :
		(!gated_mode || gate_sync));
	assign gate_fall = gated_mode && gate_prev_r && !gate_sync;
	assign match = (count_r == period_r);

	gpt_prescaler u_prescaler (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.clear_i(bus_wr && hit_control && ctrl_r.run),
		.tick_i(tick),
		.select_i(ctrl_r.prescale_select),
		.inc_o(ps_inc)
	);

	// ------------------------------------------------------------
	// Edge history
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ext_prev_r <= 1'b0;
			gate_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= ext_level;
			gate_prev_r <= gate_sync;
		end
	end

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	logic match_evt;
	logic [15:0] count_nxt;
	assign match_evt = ps_inc && match;
	// A bus write to the count wins over a tick in the same cycle, so a reload is never lost
	assign count_nxt = (bus_wr && hit_count) ? wr_lo :
		!ps_inc ? count_r :
		match ? 16'h0000 :
		count_r + 16'h0001;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			count_r <= 16'h0000;
		end else begin
			count_r <= count_nxt;
		end
	end

	// ------------------------------------------------------------
	// Control and period registers
	// ------------------------------------------------------------
	gpt_pkg::gpt_ctrl_s ctrl_wr;
	gpt_pkg::gpt_ctrl_s ctrl_nxt;
	logic [15:0] period_nxt;
	assign ctrl_wr = {wr_lo[gpt_pkg::BIT_RUN], wr_lo[gpt_pkg::BIT_IDLE_HALT], wr_lo[gpt_pkg::BIT_GATE],
		wr_lo[gpt_pkg::BIT_PS_HI:gpt_pkg::BIT_PS_LO], wr_lo[gpt_pkg::BIT_SYNC],
		wr_lo[gpt_pkg::BIT_CLK_SEL]};
	assign ctrl_nxt = (bus_wr && hit_control) ? ctrl_wr : ctrl_r;
	assign period_nxt = (bus_wr && hit_period) ? wr_lo : period_r;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_r <= '0;
			period_r <= gpt_pkg::PERIOD_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
			period_r <= period_nxt;
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, clear and enable
	// ------------------------------------------------------------
	logic [gpt_pkg::IRQ_W-1:0] events;
	logic [gpt_pkg::IRQ_W-1:0] clr_mask;
	logic [gpt_pkg::IRQ_W-1:0] enable_nxt;
	wire [gpt_pkg::IRQ_W-1:0] status_nxt;
	assign events = {gate_fall, match_evt};
	assign clr_mask = (bus_wr && hit_clear) ? wb_dat_i[gpt_pkg::IRQ_W-1:0] : '0;
	assign enable_nxt = (bus_wr && hit_enable) ? wb_dat_i[gpt_pkg::IRQ_W-1:0] : enable_r;

	// An event in the same cycle as its clear wins, so no event is lost to a late clear
	for (genvar i = 0; i < gpt_pkg::IRQ_W; i++) begin : g_status
		assign status_nxt[i] = events[i] || (status_r[i] && !clr_mask[i]);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			status_r <= '0;
			enable_r <= '0;
		end else begin
			status_r <= status_nxt;
			enable_r <= enable_nxt;
		end
	end

	// ------------------------------------------------------------
	// Bus answer and interrupt output
	// ------------------------------------------------------------
	logic [31:0] dat_nxt;
	logic irq_nxt;
	assign dat_nxt = bus_req ? rd_data : 32'h0000_0000;
	// Taken from next-cycle state so the level tracks status and enable with no extra lag
	assign irq_nxt = |(status_nxt & enable_nxt);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			irq_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= dat_nxt;
			irq_o <= irq_nxt;
		end
	end
endmodule

/* File: testbench/gpt_monitor.sv */
// Checker: bus answer and register read properties of the timer top
module gpt_monitor (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [gpt_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Shadows follow accepted writes, so control and period reads can be predicted
	logic [15:0] ctl_r;
	logic [15:0] per_r;
	wire wr_w = wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'b11;
	wire rd_w = wb_ack_o && !wb_we_i;
	wire en_w = wb_adr_i == gpt_pkg::OFS_ENABLE;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctl_r <= gpt_pkg::CONTROL_RESET;
			per_r <= gpt_pkg::PERIOD_RESET;
		end else if (wr_w && wb_adr_i == gpt_pkg::OFS_CONTROL) begin
			ctl_r <= wb_dat_i[15:0] & gpt_pkg::CONTROL_MASK;
		end else if (wr_w && wb_adr_i == gpt_pkg::OFS_PERIOD) begin
			per_r <= wb_dat_i[15:0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence pulse_s; wb_ack_o ##1 !wb_ack_o; endsequence
	ack_pulse_a: assert property (req_s |=> pulse_s)
		else $error("ack missing or too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	upper_zero_a: assert property (rd_w |-> wb_dat_o[31:16] == 16'h0)
		else $error("upper read bits not zero");
	ctrl_read_a: assert property (rd_w && wb_adr_i == gpt_pkg::OFS_CONTROL |-> wb_dat_o[15:0] == ctl_r)
		else $error("control readback wrong");
	period_read_a: assert property (rd_w && wb_adr_i == gpt_pkg::OFS_PERIOD |-> wb_dat_o[15:0] == per_r)
		else $error("period readback wrong");
	unmapped_read_a: assert property (rd_w && wb_adr_i[1:0] != 2'b00 && !en_w |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	irq_reset_a: assert property ($fell(srst_i) |-> !irq_o)
		else $error("irq high after reset");
endmodule
bind gpt_top gpt_monitor gpt_monitor_inst (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));

/* File: testbench/gpt_ext_src.sv */
// Partner: external count clock source and gate level driver
module gpt_ext_src (
	input wire logic clk_i,
	output logic pin_o,
	output logic gate_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pin rests low between bursts; 3+3 clocks per pulse so no edge is lost in sync
	initial begin
		pin_o = 1'b0;
		gate_o = 1'b0;
	end
	task automatic pulses(input int n);
		repeat (n) begin
			pin_o <= 1'b1;
			repeat (3) @(posedge clk_i);
			pin_o <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask
	task automatic gate(input logic lvl);
		gate_o <= lvl;
		@(posedge clk_i);
	endtask
endmodule

/* File: testbench/gpt_top_tb.sv */
// Testbench: registers, prescaler, match interrupt, gating and idle halt of the timer
module gpt_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic idle = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic [15:0] per;
	logic ack;
	logic irq;
	logic pin;
	logic gate;
	int err_total = 0;
	int check_count = 0;
	int dv[4] = '{1, 8, 64, 256};
	logic [31:0] exp_q[$];
	initial forever #25 clk_i = ~clk_i;
	gpt_top gpt_top_inst (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ext_count_clock_pin_i(pin), .gate_pin_i(gate), .cpu_idle_i(idle), .irq_o(irq));
	gpt_ext_src gpt_ext_src_inst (.clk_i(clk_i), .pin_o(pin), .gate_o(gate));
	task final_report;
		if (err_total == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task cmp_dat(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t read %h expected %h", $time, g, e);
		end
	endtask
	// Level output: allow a short settling window instead of a fixed latency
	task cmp_irq(input logic e);
		int n;
		n = 0;
		do begin @(negedge clk_i); n++; end while (irq !== e && n < 20);
		check_count++;
		if (irq !== e) begin
			err_total++;
			$display("[FAIL] %0t irq not %b", $time, e);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			err_total++;
			$display("[FAIL] %0t no bus answer", $time);
			final_report;
		end
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0) cmp_dat(rdat, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
	end
	initial begin
		void'($urandom(32'hdd03f21a));
		repeat (12) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		rd(gpt_pkg::OFS_CONTROL, 32'h0);
		rd(gpt_pkg::OFS_PERIOD, 32'hffff);
		rd(gpt_pkg::OFS_STATUS, 32'h0);
		rd(gpt_pkg::OFS_ENABLE, 32'h0);
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'hffffffff);
		rd(gpt_pkg::OFS_CONTROL, 32'ha076);
		rd(4'h6, 32'h0);
		per = 16'h0100 | 16'($urandom);
		bus(1'b1, gpt_pkg::OFS_PERIOD, {16'h0, per});
		rd(gpt_pkg::OFS_PERIOD, {16'h0, per});
		sel <= 4'hc;
		bus(1'b1, gpt_pkg::OFS_PERIOD, 32'h0);
		sel <= 4'hf;
		rd(gpt_pkg::OFS_PERIOD, {16'h0, per});
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h0);
			bus(1'b1, gpt_pkg::OFS_COUNT, 32'h0);
			bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h8002 | (c << 4) | ($urandom & 4));
			gpt_ext_src_inst.pulses(2 * dv[c]);
			repeat (8) @(posedge clk_i);
			rd(gpt_pkg::OFS_COUNT, 32'h2);
		end
		// A rewrite while running must drop the 4 edges already seen
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h0);
		bus(1'b1, gpt_pkg::OFS_COUNT, 32'h0);
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h8012);
		gpt_ext_src_inst.pulses(4);
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h8012);
		gpt_ext_src_inst.pulses(6);
		repeat (8) @(posedge clk_i);
		rd(gpt_pkg::OFS_COUNT, 32'h0);
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h0);
		bus(1'b1, gpt_pkg::OFS_STATUS, 32'h3);
		bus(1'b1, gpt_pkg::OFS_PERIOD, 32'h5);
		bus(1'b1, gpt_pkg::OFS_COUNT, 32'h3);
		bus(1'b1, gpt_pkg::OFS_ENABLE, 32'h3);
		rd(gpt_pkg::OFS_ENABLE, 32'h3);
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h8002);
		gpt_ext_src_inst.pulses(3);
		cmp_irq(1'b1);
		rd(gpt_pkg::OFS_STATUS, 32'h1);
		bus(1'b1, gpt_pkg::OFS_ENABLE, 32'h2);
		cmp_irq(1'b0);
		bus(1'b1, gpt_pkg::OFS_ENABLE, 32'h3);
		cmp_irq(1'b1);
		bus(1'b1, gpt_pkg::OFS_STATUS, 32'h1);
		cmp_irq(1'b0);
		rd(gpt_pkg::OFS_STATUS, 32'h0);
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h0);
		bus(1'b1, gpt_pkg::OFS_PERIOD, 32'hffff);
		bus(1'b1, gpt_pkg::OFS_COUNT, 32'h2);
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h8040);
		repeat (20) @(posedge clk_i);
		rd(gpt_pkg::OFS_COUNT, 32'h2);
		gpt_ext_src_inst.gate(1'b1);
		repeat (10) @(posedge clk_i);
		gpt_ext_src_inst.gate(1'b0);
		cmp_irq(1'b1);
		rd(gpt_pkg::OFS_STATUS, 32'h2);
		rd(gpt_pkg::OFS_COUNT, 32'hd);
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h0);
		bus(1'b1, gpt_pkg::OFS_STATUS, 32'h3);
		bus(1'b1, gpt_pkg::OFS_COUNT, 32'h0);
		idle <= 1'b1;
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'ha000);
		repeat (20) @(posedge clk_i);
		rd(gpt_pkg::OFS_COUNT, 32'h0);
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h8000);
		repeat (20) @(posedge clk_i);
		rd(gpt_pkg::OFS_COUNT, 32'h16);
		idle <= 1'b0;
		bus(1'b1, gpt_pkg::OFS_CONTROL, 32'h0);
		bus(1'b1, gpt_pkg::OFS_COUNT, 32'h5);
		repeat (20) @(posedge clk_i);
		rd(gpt_pkg::OFS_COUNT, 32'h5);
		final_report;
	end
endmodule
